// *** rtl/dp_pkg.sv ***
package dp_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] MASK_OFS   = 8'h04;
    localparam logic [7:0] ROUTE_OFS  = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0C;
    localparam logic [7:0] WORD_BASE  = 8'h20;
    localparam int         WORD_COUNT = 8;

    // Static control register field positions
    localparam int CTL_SOSEL  = 0;
    localparam int CTL_MSBSEL = 1;
    localparam int CTL_MSBEN  = 4;
    localparam int CTL_MSBSI  = 5;
    localparam int CTL_DEFSI  = 6;
    localparam int CTL_SIA    = 7;
    localparam int CTL_SIB    = 9;
    localparam int CTL_CIA    = 11;
    localparam int CTL_CIB    = 13;
    localparam int CTL_INS0   = 15;
    localparam int CTL_INS1   = 17;
    localparam int CTRL_W     = 19;

    // Dynamic configuration word field positions
    localparam int DW_SHIFT = 0;
    localparam int DW_SISEL = 2;
    localparam int DW_CISEL = 3;

    // Routed input indices and selector widths
    localparam int IN_ADDR_LO = 0;
    localparam int IN_ADDR_MI = 1;
    localparam int IN_ADDR_HI = 2;
    localparam int IN_Q0_LD   = 3;
    localparam int IN_Q1_LD   = 4;
    localparam int IN_OP0_LD  = 5;
    localparam int IN_OP1_LD  = 6;
    localparam int IN_SHIFTIN = 7;
    localparam int IN_CARRY   = 8;
    localparam int NUM_INPUTS = 9;
    localparam int ROUTE_W    = 6;
    localparam int SEL_W      = 3;

    // Reset values
    localparam logic [7:0] MASK_RST = 8'hFF;
    localparam logic [2:0] MSB_TOP  = 3'h7;

    typedef enum logic [1:0] {SH_PASS, SH_LEFT, SH_RIGHT, SH_SWAP}
        shift_op_type;
    typedef enum logic [1:0] {SI_DEFAULT, SI_REGISTERED, SI_ROUTED,
        SI_CHAINED} shiftin_src_type;
    typedef enum logic [1:0] {CI_DEFAULT, CI_REGISTERED, CI_ROUTED,
        CI_CHAINED} carry_mode_type;
    typedef enum logic [1:0] {SRC_BUS, SRC_ACC0, SRC_ACC1, SRC_ALU}
        queue_src_type;

    // Register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_type;

    // Whole state of the slice
    typedef struct packed {
        logic [CTRL_W-1:0]               ctrl;
        logic [7:0]                      mask;
        logic [NUM_INPUTS*SEL_W-1:0]     route;
        logic [WORD_COUNT-1:0][15:0]     words;
        logic                            carry_flag;
        logic                            sol;
        logic                            sor;
        logic [3:0]                      hist;
        logic [3:0]                      pend;
        logic [31:0]                     rdata;
        logic [7:0]                      result;
        logic                            shift_out;
        logic [1:0]                      carry_mode;
        logic                            carry_to_alu;
        logic [15:0]                     dyn_word;
        logic [1:0]                      q_wr;
        logic [1:0][7:0]                 q_wdata;
        logic [1:0][7:0]                 operand;
    } state_type;

    localparam state_type STATE_RST = '{mask: MASK_RST, default: '0};

endpackage : dp_pkg

// *** rtl/dp_shift_mask.sv ***
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
// Function
// - Register carry out for next operation
// - Two-bit shift control: pass, left, right, swap
// - Static bit picks left or right shift-out
// - Without shift, shift-outs are result LSb/MSb
// - Word picks shift-in source A or B
// - Shift-in used only on left/right shifts
// - Source 00: default bit or MSb arithmetic
// - Source 01: previous registered shift-out
// - Source 10: routed serial input
// - Source 11: neighbour slice chain inputs
// - Left out and right in use MSb position
// - Both shift-outs registered every cycle
// - Bits above MSb shift, their outs lost
// - Result ANDed with 8-bit mask
// - Three-bit address selects 16-bit config word
// - Queue load on rising edge, source select
// - Operand register load from queue on edge
// - Routed carry used only in routed mode
// - Each of nine inputs has six-way selector
// - Loads edge sensitive, others level sensitive
// - Carry select 10 uses routed carry
module dp_shift_mask
    import dp_pkg::*;
(
    input  wire logic               mclk_in,
    input  wire logic               rst_n_in,
    input  wire bus_req_type        bus_in,
    output logic [31:0]             rdata_out,
    input  wire logic [ROUTE_W-1:0] route_in,
    input  wire logic [7:0]         alu_result_in,
    input  wire logic               alu_carry_out_in,
    input  wire logic               chain_carry_in,
    input  wire logic               chain_from_right_in,
    input  wire logic               chain_from_left_in,
    input  wire logic [7:0]         accumulator_zero_in,
    input  wire logic [7:0]         accumulator_one_in,
    input  wire logic [7:0]         queue_zero_in,
    input  wire logic [7:0]         queue_one_in,
    output logic [7:0]              result_out,
    output logic                    shift_out,
    output logic                    sol_reg_out,
    output logic                    sor_reg_out,
    output logic [1:0]              carry_mode_out,
    output logic                    carry_to_alu_out,
    output logic [15:0]             dynamic_config_word_out,
    output logic                    queue_zero_wr_out,
    output logic [7:0]              queue_zero_wdata_out,
    output logic                    queue_one_wr_out,
    output logic [7:0]              queue_one_wdata_out,
    output logic [7:0]              operand_reg_zero_out,
    output logic [7:0]              operand_reg_one_out
);

    state_type                s_q;
    state_type                s_d;
    logic [NUM_INPUTS-1:0]    routed_c;
    logic [2:0]               cfg_addr_c;
    logic [15:0]              cur_word_c;
    shift_op_type             shift_op_c;
    shiftin_src_type          si_src_c;
    carry_mode_type           ci_mode_c;
    logic [2:0]               msb_pos_c;
    logic                     sil_c;
    logic                     sir_c;
    logic [7:0]               shifted_c;
    logic [3:0]               load_c;
    logic [3:0]               rise_c;

    // Six-way routing selector per input
    for (genvar g = 0; g < NUM_INPUTS; g++)
    begin : g_route
        logic [SEL_W-1:0] sel;
        assign sel = s_q.route[g*SEL_W +: SEL_W];
        assign routed_c[g] = (sel < SEL_W'(ROUTE_W)) ?
                             route_in[sel] : 1'b0;
    end

    // Level inputs straight, load inputs through edge detectors
    assign cfg_addr_c = {routed_c[IN_ADDR_HI], routed_c[IN_ADDR_MI],
                         routed_c[IN_ADDR_LO]};
    assign load_c     = {routed_c[IN_OP1_LD], routed_c[IN_OP0_LD],
                         routed_c[IN_Q1_LD], routed_c[IN_Q0_LD]};
    assign rise_c     = load_c & ~s_q.hist;

    // Next-state logic
    always_comb
    begin
        s_d = s_q;
        cur_word_c = s_q.words[cfg_addr_c];
        shift_op_c = shift_op_type'(cur_word_c[DW_SHIFT +: 2]);
        si_src_c = cur_word_c[DW_SISEL] ?
            shiftin_src_type'(s_q.ctrl[CTL_SIB +: 2]) :
            shiftin_src_type'(s_q.ctrl[CTL_SIA +: 2]);
        ci_mode_c = cur_word_c[DW_CISEL] ?
            carry_mode_type'(s_q.ctrl[CTL_CIB +: 2]) :
            carry_mode_type'(s_q.ctrl[CTL_CIA +: 2]);
        msb_pos_c = s_q.ctrl[CTL_MSBEN] ?
            s_q.ctrl[CTL_MSBSEL +: 3] : MSB_TOP;

        // Shift-in source for each direction
        unique case (si_src_c)
            SI_DEFAULT:
            begin
                sil_c = s_q.ctrl[CTL_DEFSI];
                sir_c = s_q.ctrl[CTL_MSBSI] ?
                    alu_result_in[msb_pos_c] : s_q.ctrl[CTL_DEFSI];
            end
            SI_REGISTERED:
            begin
                sil_c = s_q.sol;
                sir_c = s_q.sor;
            end
            SI_ROUTED:
            begin
                sil_c = routed_c[IN_SHIFTIN];
                sir_c = routed_c[IN_SHIFTIN];
            end
            SI_CHAINED:
            begin
                sil_c = chain_from_right_in;
                sir_c = chain_from_left_in;
            end
        endcase

        // Shifter; shift-outs of isolated upper bits are dropped
        shifted_c = alu_result_in;
        s_d.sol = alu_result_in[msb_pos_c];
        s_d.sor = alu_result_in[0];
        unique case (shift_op_c)
            SH_PASS:
                shifted_c = alu_result_in;
            SH_LEFT:
            begin
                shifted_c = {alu_result_in[6:0], sil_c};
            end
            SH_RIGHT:
            begin
                for (int i = 0; i < 8; i++)
                begin
                    if (i == int'(msb_pos_c) || i == 7)
                        shifted_c[i] = sir_c;
                    else
                        shifted_c[i] = alu_result_in[i+1];
                end
            end
            SH_SWAP:
                shifted_c = {alu_result_in[3:0],
                             alu_result_in[7:4]};
        endcase

        // Registered shift-outs and carry for later cycles
        s_d.carry_flag = alu_carry_out_in;
        s_d.result = shifted_c & s_q.mask;
        s_d.shift_out = s_q.ctrl[CTL_SOSEL] ?
                        s_d.sol : s_d.sor;
        s_d.dyn_word = cur_word_c;
        s_d.carry_mode = ci_mode_c;
        unique case (ci_mode_c)
            CI_DEFAULT:    s_d.carry_to_alu = 1'b0;
            CI_REGISTERED: s_d.carry_to_alu = s_q.carry_flag;
            CI_ROUTED:     s_d.carry_to_alu = routed_c[IN_CARRY];
            CI_CHAINED:    s_d.carry_to_alu = chain_carry_in;
        endcase

        // Edge detection: sample, then act on the following edge
        s_d.hist = load_c;
        s_d.pend = rise_c;
        for (int q = 0; q < 2; q++)
        begin
            s_d.q_wr[q] = 1'b0;
            if (s_q.pend[q])
            begin
                unique case (queue_src_type'(s_q.ctrl[(q == 0 ?
                    CTL_INS0 : CTL_INS1) +: 2]))
                    SRC_BUS:  s_d.q_wr[q] = 1'b0;
                    SRC_ACC0:
                    begin
                        s_d.q_wr[q] = 1'b1;
                        s_d.q_wdata[q] = accumulator_zero_in;
                    end
                    SRC_ACC1:
                    begin
                        s_d.q_wr[q] = 1'b1;
                        s_d.q_wdata[q] = accumulator_one_in;
                    end
                    SRC_ALU:
                    begin
                        s_d.q_wr[q] = 1'b1;
                        s_d.q_wdata[q] = alu_result_in;
                    end
                endcase
            end
        end
        if (s_q.pend[2])
            s_d.operand[0] = queue_zero_in;
        if (s_q.pend[3])
            s_d.operand[1] = queue_one_in;

        // Register writes
        if (bus_in.wr)
        begin
            if (bus_in.addr == CTRL_OFS)
                s_d.ctrl = bus_in.wdata[CTRL_W-1:0];
            else if (bus_in.addr == MASK_OFS)
                s_d.mask = bus_in.wdata[7:0];
            else if (bus_in.addr == ROUTE_OFS)
                s_d.route = bus_in.wdata[NUM_INPUTS*SEL_W-1:0];
            else if (bus_in.addr >= WORD_BASE &&
                     bus_in.addr[1:0] == 2'h0 &&
                     bus_in.addr < WORD_BASE + 8'(WORD_COUNT*4))
                s_d.words[bus_in.addr[4:2]] = bus_in.wdata[15:0];
        end

        // Register reads, data valid in the next cycle only
        s_d.rdata = 32'h0000_0000;
        if (bus_in.rd)
        begin
            if (bus_in.addr == CTRL_OFS)
                s_d.rdata = {13'h0000, s_q.ctrl};
            else if (bus_in.addr == MASK_OFS)
                s_d.rdata = {24'h00_0000, s_q.mask};
            else if (bus_in.addr == ROUTE_OFS)
                s_d.rdata = {5'h00, s_q.route};
            else if (bus_in.addr == STATUS_OFS)
                s_d.rdata = {10'h000, cfg_addr_c, s_q.sor, s_q.sol,
                             s_q.carry_flag, s_q.operand[1],
                             s_q.operand[0]};
            else if (bus_in.addr >= WORD_BASE &&
                     bus_in.addr[1:0] == 2'h0 &&
                     bus_in.addr < WORD_BASE + 8'(WORD_COUNT*4))
                s_d.rdata = {16'h0000, s_q.words[bus_in.addr[4:2]]};
        end
    end

    // State register
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
            s_q <= STATE_RST;
        else
            s_q <= s_d;
    end

    // Outputs straight from the state register
    assign rdata_out               = s_q.rdata;
    assign result_out              = s_q.result;
    assign shift_out               = s_q.shift_out;
    assign sol_reg_out             = s_q.sol;
    assign sor_reg_out             = s_q.sor;
    assign carry_mode_out          = s_q.carry_mode;
    assign carry_to_alu_out        = s_q.carry_to_alu;
    assign dynamic_config_word_out = s_q.dyn_word;
    assign queue_zero_wr_out       = s_q.q_wr[0];
    assign queue_zero_wdata_out    = s_q.q_wdata[0];
    assign queue_one_wr_out        = s_q.q_wr[1];
    assign queue_one_wdata_out     = s_q.q_wdata[1];
    assign operand_reg_zero_out    = s_q.operand[0];
    assign operand_reg_one_out     = s_q.operand[1];

    // Checks
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    carry_flag_a: assert property (
        ##1 s_q.carry_flag == $past(alu_carry_out_in))
        else $error("carry flag not registered");
    pass_mask_a: assert property (
        shift_op_c == SH_PASS |=>
        result_out == ($past(alu_result_in) & $past(s_q.mask)))
        else $error("pass result wrong");
    swap_op_a: assert property (
        shift_op_c == SH_SWAP && s_q.mask == 8'hFF && !bus_in.wr |=>
        result_out[3:0] == $past(alu_result_in[7:4]) &&
        result_out[7:4] == $past(alu_result_in[3:0]))
        else $error("nibble swap wrong");
    shift_out_a: assert property (
        shift_out == ($past(s_q.ctrl[CTL_SOSEL]) ? $past(s_d.sol) :
                      $past(s_d.sor)) || $rose(rst_n_in))
        else $error("shift out select wrong");
    sor_pass_a: assert property (
        shift_op_c != SH_LEFT && shift_op_c != SH_RIGHT |=>
        sor_reg_out == $past(alu_result_in[0]))
        else $error("sor not result lsb");
    reg_shiftin_a: assert property (
        shift_op_c == SH_LEFT && si_src_c == SI_REGISTERED |->
        shifted_c[0] == s_q.sol)
        else $error("registered shift in wrong");
    routed_right_a: assert property (
        shift_op_c == SH_RIGHT && si_src_c == SI_ROUTED |->
        shifted_c[msb_pos_c] == routed_c[IN_SHIFTIN])
        else $error("routed right shift wrong");
    config_word_a: assert property (
        ##1 dynamic_config_word_out == $past(cur_word_c))
        else $error("config word not selected");
    queue_load_a: assert property (
        rise_c[0] && s_q.ctrl[CTL_INS0 +: 2] != 2'h0 && !bus_in.wr |->
        ##2 queue_zero_wr_out)
        else $error("queue load missed");
    operand_load_a: assert property (
        rise_c[2] |-> ##1 s_q.pend[2] ##1
        operand_reg_zero_out == $past(queue_zero_in))
        else $error("operand load wrong");
    routed_carry_a: assert property (
        ci_mode_c == CI_ROUTED |=>
        carry_to_alu_out == $past(routed_c[IN_CARRY]))
        else $error("routed carry not used");
    no_edge_a: assert property (
        !s_q.pend[1] |=> !queue_one_wr_out)
        else $error("queue write without edge");

    swap_cov: cover property (shift_op_c == SH_SWAP);
    qload_cov: cover property (rise_c[0] ##2 queue_zero_wr_out);
    chain_cov: cover property (shift_op_c == SH_RIGHT &&
                               si_src_c == SI_CHAINED);

endmodule : dp_shift_mask

// *** tb/dp_fabric_model.sv ***
`timescale 1ns/10ps
module dp_fabric_model (
    input  wire logic       mclk_in,
    output logic [5:0]      route_out,
    output logic            from_right_out,
    output logic            from_left_out,
    output logic            chain_carry_out
);
    logic [2:0] addr_q;
    logic       load_q;
    logic       shiftin_q;
    logic       routed_carry_q;

    // Routing channel bits as the slice sees them
    assign route_out = {routed_carry_q, shiftin_q, load_q, addr_q};

    // Quiet fabric at time zero
    initial
    begin
        {addr_q, load_q, shiftin_q, routed_carry_q} = '0;
        {from_right_out, from_left_out, chain_carry_out} = '0;
    end

    // Level signals, changed just after an edge
    task automatic set_levels(input logic [2:0] a, input logic [4:0] v);
        addr_q <= a;
        {shiftin_q, routed_carry_q} <= v[4:3];
        {from_right_out, from_left_out, chain_carry_out} <= v[2:0];
    endtask : set_levels

    // Load strobe as a clean rise, held n edges, then low
    task automatic raise_load(input int n);
        load_q <= 1'h1;
        repeat (n) @(posedge mclk_in);
        load_q <= 1'h0;
    endtask : raise_load
endmodule : dp_fabric_model

// *** tb/dp_shift_mask_tb_top.sv ***
`timescale 1ns/10ps
module dp_shift_mask_tb_top;
    import dp_pkg::*;

    typedef struct packed {
        logic [18:0] ctrl;
        logic [2:0]  addr;
        logic [4:0]  lv;
        logic [7:0]  res;
        logic [4:0]  fl;
    } case_type;

    // Config words: shift op, shift-in B, carry B
    localparam logic [15:0] WORDS [8] = '{16'h0000, 16'h0001, 16'h0002,
        16'h0003, 16'h0005, 16'h0006, 16'h0008, 16'h0004};
    // Control, address, levels, result, {sol, sor, mode, carry}
    localparam case_type ROWS [27] = '{
        '{19'h00041, 3'h0, 5'h00, 8'h96, 5'h10},
        '{19'h00040, 3'h1, 5'h00, 8'h2D, 5'h10},
        '{19'h00041, 3'h2, 5'h00, 8'hCB, 5'h10},
        '{19'h00040, 3'h3, 5'h00, 8'h69, 5'h10},
        '{19'h00100, 3'h3, 5'h10, 8'h69, 5'h10},
        '{19'h00020, 3'h2, 5'h00, 8'hCB, 5'h10},
        '{19'h00020, 3'h1, 5'h00, 8'h2C, 5'h10},
        '{19'h00080, 3'h1, 5'h00, 8'h2D, 5'h10},
        '{19'h00080, 3'h2, 5'h00, 8'h4B, 5'h10},
        '{19'h00100, 3'h1, 5'h10, 8'h2D, 5'h10},
        '{19'h00100, 3'h2, 5'h10, 8'hCB, 5'h10},
        '{19'h00100, 3'h1, 5'h00, 8'h2C, 5'h10},
        '{19'h00180, 3'h1, 5'h04, 8'h2D, 5'h10},
        '{19'h00180, 3'h2, 5'h04, 8'h4B, 5'h10},
        '{19'h00180, 3'h2, 5'h02, 8'hCB, 5'h10},
        '{19'h00400, 3'h4, 5'h10, 8'h2D, 5'h10},
        '{19'h00400, 3'h5, 5'h10, 8'hCB, 5'h10},
        '{19'h00400, 3'h1, 5'h10, 8'h2C, 5'h10},
        '{19'h0005B, 3'h2, 5'h00, 8'hEB, 5'h00},
        '{19'h0005B, 3'h1, 5'h00, 8'h2D, 5'h00},
        '{19'h0003A, 3'h2, 5'h00, 8'h4B, 5'h00},
        '{19'h00000, 3'h0, 5'h09, 8'h96, 5'h10},
        '{19'h01000, 3'h0, 5'h08, 8'h96, 5'h15},
        '{19'h01000, 3'h0, 5'h01, 8'h96, 5'h14},
        '{19'h01800, 3'h0, 5'h01, 8'h96, 5'h17},
        '{19'h04000, 3'h6, 5'h08, 8'h96, 5'h15},
        '{19'h04000, 3'h0, 5'h08, 8'h96, 5'h10}};

    logic        mclk_in;
    logic        rst_n_in;
    bus_req_type bus;
    logic [31:0] rdata_out;
    logic [5:0]  route;
    logic [7:0]  alu;
    logic        co;
    logic        fr;
    logic        fl;
    logic        cc;
    logic [7:0]  acc0;
    logic [7:0]  acc1;
    logic [7:0]  q0;
    logic [7:0]  q1;
    logic [7:0]  result_out;
    logic        shift_out;
    logic        sol_reg_out;
    logic        sor_reg_out;
    logic [1:0]  carry_mode_out;
    logic        carry_to_alu_out;
    logic [15:0] dynamic_config_word_out;
    logic        q0_wr;
    logic [7:0]  q0_data;
    logic        q1_wr;
    logic [7:0]  q1_data;
    logic [7:0]  op0;
    logic [7:0]  op1;
    int          failures;
    int          num_checks;
    int          q0_cnt;
    int          q1_cnt;

    dp_shift_mask dp_shift_mask_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .bus_in(bus), .rdata_out(rdata_out), .route_in(route),
        .alu_result_in(alu), .alu_carry_out_in(co), .chain_carry_in(cc),
        .chain_from_right_in(fr), .chain_from_left_in(fl),
        .accumulator_zero_in(acc0), .accumulator_one_in(acc1),
        .queue_zero_in(q0), .queue_one_in(q1), .result_out(result_out),
        .shift_out(shift_out), .sol_reg_out(sol_reg_out),
        .sor_reg_out(sor_reg_out), .carry_mode_out(carry_mode_out),
        .carry_to_alu_out(carry_to_alu_out),
        .dynamic_config_word_out(dynamic_config_word_out),
        .queue_zero_wr_out(q0_wr), .queue_zero_wdata_out(q0_data),
        .queue_one_wr_out(q1_wr), .queue_one_wdata_out(q1_data),
        .operand_reg_zero_out(op0), .operand_reg_one_out(op1));

    dp_fabric_model dp_fabric_model_i (.mclk_in(mclk_in), .route_out(route),
        .from_right_out(fr), .from_left_out(fl), .chain_carry_out(cc));

    // Clock and queue write pulse counters
    always #20 mclk_in = ~mclk_in;
    always @(posedge mclk_in)
    begin
        if (q0_wr === 1'h1)
            q0_cnt <= q0_cnt + 1;
        if (q1_wr === 1'h1)
            q1_cnt <= q1_cnt + 1;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : chk

    task automatic give_verdict;
        if (failures == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        @(posedge mclk_in);
        bus <= '0;
    endtask : wr

    // Read data stands one cycle only
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk_in);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'h0, rd: 1'h1};
        @(posedge mclk_in);
        bus <= '0;
        #1;
        chk(rdata_out, e);
        @(posedge mclk_in);
        #1;
        chk(rdata_out, 32'h0);
    endtask : rd

    task automatic t_regs;
        rd(MASK_OFS, 32'h000000FF);
        rd(CTRL_OFS, 32'h0);
        rd(8'h10, 32'h0);
        wr(ROUTE_OFS, 32'h058DB688);
        rd(ROUTE_OFS, 32'h058DB688);
        for (int i = 0; i < WORD_COUNT; i++)
            wr(8'(WORD_BASE + 4 * i), 32'(WORDS[i]));
        rd(8'h34, 32'h6);
    endtask : t_regs

    // Shifter, shift-in sources and carry selection table
    task automatic t_table;
        case_type c;
        for (int i = 0; i < 27; i++)
        begin
            c = ROWS[i];
            wr(CTRL_OFS, 32'(c.ctrl));
            dp_fabric_model_i.set_levels(c.addr, c.lv);
            repeat (2) @(posedge mclk_in);
            #1;
            chk(result_out, c.res);
            chk({result_out, sol_reg_out}, {c.res, c.fl[4]});
            chk({result_out, c.addr}, {c.res, c.addr});
            chk({sol_reg_out, sor_reg_out}, c.fl[4:3]);
            chk(shift_out, c.ctrl[0] ? c.fl[4] : c.fl[3]);
            chk({carry_mode_out, carry_to_alu_out}, c.fl[2:0]);
            chk(dynamic_config_word_out, WORDS[c.addr]);
        end
    endtask : t_table

    // Stored carry seen one operation later
    task automatic t_carry_reg;
        wr(CTRL_OFS, 32'h0800);
        dp_fabric_model_i.set_levels(3'h0, 5'h00);
        co <= 1'h1;
        repeat (2) @(posedge mclk_in);
        co <= 1'h0;
        @(posedge mclk_in);
        #1;
        chk({carry_mode_out, carry_to_alu_out}, 3'h3);
        @(posedge mclk_in);
        #1;
        chk(carry_to_alu_out, 1'h0);
    endtask : t_carry_reg

    // Mask applied after a right shift
    task automatic t_mask;
        wr(MASK_OFS, 32'hF0);
        wr(CTRL_OFS, 32'h0);
        dp_fabric_model_i.set_levels(3'h2, 5'h00);
        repeat (2) @(posedge mclk_in);
        #1;
        chk(result_out, 8'h40);
        wr(MASK_OFS, 32'hFF);
    endtask : t_mask

    // Edge-detected queue and operand loads
    task automatic t_loads;
        wr(CTRL_OFS, 32'h68000);
        dp_fabric_model_i.set_levels(3'h0, 5'h00);
        dp_fabric_model_i.raise_load(1);
        #1;
        chk({q0_wr, q1_wr}, 2'h0);
        @(posedge mclk_in);
        #1;
        chk({q0_wr, q0_data, q1_wr, q1_data}, 18'h2B596);
        chk({op0, op1}, 16'h1122);
        @(posedge mclk_in);
        #1;
        chk({q0_wr, q1_wr}, 2'h0);
        rd(STATUS_OFS, 32'h00022211);
        q0_cnt = 0;
        q1_cnt = 0;
        wr(CTRL_OFS, 32'h8000);
        dp_fabric_model_i.raise_load(6);
        repeat (3) @(posedge mclk_in);
        #1;
        chk(q0_cnt, 1);
        chk(q1_cnt, 0);
    endtask : t_loads

    // Main sequence
    initial
    begin
        mclk_in = 1'h0;
        rst_n_in = 1'h0;
        bus = '0;
        alu = 8'h96;
        co = 1'h0;
        acc0 = 8'h5A;
        acc1 = 8'hA5;
        q0 = 8'h11;
        q1 = 8'h22;
        failures = 0;
        num_checks = 0;
        q0_cnt = 0;
        q1_cnt = 0;
        repeat (20) @(posedge mclk_in);
        rst_n_in <= 1'h1;
        t_regs;
        t_table;
        t_carry_reg;
        t_mask;
        t_loads;
        give_verdict;
    end

    // Watchdog
    initial
    begin
        repeat (3000) @(posedge mclk_in);
        failures++;
        give_verdict;
    end
endmodule : dp_shift_mask_tb_top
